// >>> swg_pkg.sv
package swg_pkg;

    // Timebase
    localparam int CLK_PERIOD_NS = 10;

    // Nominal timing at frequency select 00b, in ns
    localparam int LP_PERIOD_NS  = 41667;
    localparam int MP_PERIOD_NS  = 2604;
    localparam int HP_PERIOD_NS  = 1953;
    localparam int MAX_ON_NS     = 1017;
    localparam int Y_OFFSET_NS   = 1302;

    // Duty ceilings in per mille
    localparam int LP_DUTY_PM    = 25;
    localparam int MP_DUTY_PM    = 304;
    localparam int HP_DUTY_PM    = 520;
    localparam int PM_FULL       = 1000;

    // Blanking choices in ns, indexed by the 2-bit blanking code
    localparam int BLANK0_NS     = 41;
    localparam int BLANK1_NS     = 81;
    localparam int BLANK2_NS     = 120;
    localparam int BLANK3_NS     = 160;

    localparam int CNT_W         = 13;
    localparam int BLANK_W       = 5;

    // Periods and longest times round down; blanking is a least time, rounds up
    localparam logic [CNT_W-1:0] LP_PERIOD_CYC = CNT_W'(LP_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MP_PERIOD_CYC = CNT_W'(MP_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HP_PERIOD_CYC = CNT_W'(HP_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MAX_ON_CYC    = CNT_W'(MAX_ON_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] Y_OFFSET_CYC  = CNT_W'(Y_OFFSET_NS / CLK_PERIOD_NS);
    localparam logic [BLANK_W-1:0] BLANK0_CYC  =
        BLANK_W'((BLANK0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [BLANK_W-1:0] BLANK1_CYC  =
        BLANK_W'((BLANK1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [BLANK_W-1:0] BLANK2_CYC  =
        BLANK_W'((BLANK2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [BLANK_W-1:0] BLANK3_CYC  =
        BLANK_W'((BLANK3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Register indices; byte address is four times the index
    localparam logic [7:0]  PARAM_IDX   = 8'hE4;
    localparam logic [7:0]  CTRL_IDX    = 8'hE6;
    localparam logic [7:0]  STATUS_IDX  = 8'hE8;
    localparam logic [11:0] PARAM_ADDR  = {2'b00, PARAM_IDX, 2'b00};
    localparam logic [11:0] CTRL_ADDR   = {2'b00, CTRL_IDX, 2'b00};
    localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};

    // Parameter register fields
    localparam int FS_LSB    = 0;
    localparam int BLANK_LSB = 2;
    localparam logic [7:0] PARAM_RST = 8'h08;
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // Control register mode codes
    localparam logic [7:0] CODE_LOW  = 8'h01;
    localparam logic [7:0] CODE_MED  = 8'h02;
    localparam logic [7:0] CODE_HIGH = 8'h03;

    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_LOW  = 2'b01,
        MODE_MED  = 2'b10,
        MODE_HIGH = 2'b11
    } power_mode_t;

    typedef enum logic {
        PULSE_IDLE = 1'b0,
        PULSE_ON   = 1'b1
    } pulse_state_t;

endpackage

// >>> gate_pulse_if.sv
`timescale 1ns/1ps
interface gate_pulse_if;
    import swg_pkg::*;
    logic                 start;
    logic                 enable;
    logic [CNT_W-1:0]     on_cap;
    logic [BLANK_W-1:0]   blank_cyc;
    logic                 trip;
    logic                 gate;
    logic                 blanking;

    modport ctrl  (output start, enable, on_cap, blank_cyc, trip, input gate, blanking);
    modport timer (input start, enable, on_cap, blank_cyc, trip, output gate, blanking);
endinterface

// >>> gate_pulse_timer.sv
`timescale 1ns/1ps
module gate_pulse_timer
    import swg_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    gate_pulse_if.timer gp
);

    pulse_state_t     state_r;
    pulse_state_t     state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             blank_r;
    logic             blank_nxt;
    logic             end_now;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        // Trip is only honoured once the blanking count has passed
        end_now   = (cnt_r + 1'b1 >= gp.on_cap) ||
                    (gp.trip && (cnt_r >= CNT_W'(gp.blank_cyc))) ||
                    !gp.enable;
        case (state_r)
            PULSE_IDLE: begin
                cnt_nxt = '0;
                if (gp.start && gp.enable && (gp.on_cap != '0)) begin
                    state_nxt = PULSE_ON;
                end
            end
            PULSE_ON: begin
                cnt_nxt = cnt_r + 1'b1;
                if (end_now) begin
                    state_nxt = PULSE_IDLE;
                    cnt_nxt   = '0;
                end
            end
            default: begin
                state_nxt = PULSE_IDLE;
            end
        endcase
        blank_nxt = (state_nxt == PULSE_ON) && (cnt_nxt < CNT_W'(gp.blank_cyc));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PULSE_IDLE;
            cnt_r   <= '0;
            blank_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            blank_r <= blank_nxt;
        end
    end

    assign gp.gate     = (state_r == PULSE_ON);
    assign gp.blanking = blank_r;

endmodule

// >>> switcher_gate_pwm_timing.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module switcher_gate_pwm_timing
    import swg_pkg::*;
#(
    parameter logic [CNT_W-1:0] LP_PERIOD = LP_PERIOD_CYC
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        current_sense_in_y,
    input  wire logic        current_sense_in_z,
    output logic             gate_drive_out_y,
    output logic             gate_drive_out_z
);

    // Which register a bus address names
    typedef enum logic [1:0] {
        SEL_NONE   = 2'b00,
        SEL_PARAM  = 2'b01,
        SEL_CTRL   = 2'b10,
        SEL_STATUS = 2'b11
    } reg_sel_t;

    gate_pulse_if gp_y ();
    gate_pulse_if gp_z ();

    logic [7:0]         param_r;
    logic [7:0]         param_nxt;
    logic [7:0]         ctrl_r;
    logic [7:0]         ctrl_nxt;
    logic [31:0]        prdata_r;
    logic [31:0]        prdata_nxt;
    logic               pready_r;
    logic               pready_nxt;
    logic               pslverr_r;
    logic               pslverr_nxt;
    logic [CNT_W-1:0]   per_cnt_r;
    logic [CNT_W-1:0]   per_cnt_nxt;
    power_mode_t        mode_r;
    power_mode_t        mode_nxt;
    power_mode_t        mode_dec;
    logic [1:0]         fs;
    logic [1:0]         blank_code;
    logic [CNT_W-1:0]   period_cyc;
    logic [CNT_W-1:0]   offset_cyc;
    logic [CNT_W-1:0]   cap_cyc;
    logic [BLANK_W-1:0] blank_cyc;
    logic               active;
    logic               access;
    logic               mapped;
    logic [7:0]         status;
    reg_sel_t           sel;

    // Mode comes from the whole control byte; any other value parks the outputs
    function automatic power_mode_t decode_mode(input logic [7:0] code);
        if (code == CODE_LOW) begin
            return MODE_LOW;
        end else if (code == CODE_MED) begin
            return MODE_MED;
        end else if (code == CODE_HIGH) begin
            return MODE_HIGH;
        end else begin
            return MODE_OFF;
        end
    endfunction

    // Higher frequency select divides period, offset and longest on time, not blanking; never below one cycle
    function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] c,
                                              input logic [1:0]       f);
        logic [CNT_W-1:0] r;
        case (f)
            2'b00:   r = c;
            2'b01:   r = c >> 1;
            2'b10:   r = CNT_W'(c / 3);
            default: r = c >> 2;
        endcase
        return (r == '0) ? CNT_W'(1) : r;
    endfunction

    function automatic logic [CNT_W-1:0] duty_cap(input logic [CNT_W-1:0] per,
                                                 input int               pm);
        int prod;
        prod = int'(per) * pm / PM_FULL;
        return CNT_W'(prod);
    endfunction

    function automatic logic [BLANK_W-1:0] blank_of(input logic [1:0] code);
        case (code)
            2'b00:   return BLANK0_CYC;
            2'b01:   return BLANK1_CYC;
            2'b10:   return BLANK2_CYC;
            default: return BLANK3_CYC;
        endcase
    endfunction

    // One decode serves the write side and the read side alike
    function automatic reg_sel_t decode_addr(input logic [11:0] a);
        if (a == PARAM_ADDR) begin
            return SEL_PARAM;
        end else if (a == CTRL_ADDR) begin
            return SEL_CTRL;
        end else if (a == STATUS_ADDR) begin
            return SEL_STATUS;
        end else begin
            return SEL_NONE;
        end
    endfunction

    assign fs         = param_r[FS_LSB +: 2];
    assign blank_code = param_r[BLANK_LSB +: 2];
    assign mode_dec   = decode_mode(ctrl_r);
    assign active     = (mode_r != MODE_OFF);
    assign blank_cyc  = blank_of(blank_code);

    always_comb begin
        logic [CNT_W-1:0] nom_per;
        logic [CNT_W-1:0] on_lim;
        logic [CNT_W-1:0] duty_lim;
        int               pm;
        nom_per  = LP_PERIOD;
        pm       = LP_DUTY_PM;
        on_lim   = '0;
        duty_lim = '0;
        case (mode_r)
            MODE_LOW: begin
                nom_per = LP_PERIOD;
                pm      = LP_DUTY_PM;
            end
            MODE_MED: begin
                nom_per = MP_PERIOD_CYC;
                pm      = MP_DUTY_PM;
            end
            MODE_HIGH: begin
                nom_per = HP_PERIOD_CYC;
                pm      = HP_DUTY_PM;
            end
            default: begin
                nom_per = LP_PERIOD;
                pm      = LP_DUTY_PM;
            end
        endcase
        period_cyc = scale(nom_per, fs);
        offset_cyc = scale(Y_OFFSET_CYC, fs);
        // Duty ceiling uses the unscaled ratio, so it holds at every select
        on_lim     = scale(MAX_ON_CYC, fs);
        duty_lim   = duty_cap(period_cyc, pm);
        cap_cyc    = (duty_lim < on_lim) ? duty_lim : on_lim;
    end

    // Period counter; a mode or select change restarts it so no runt period appears
    always_comb begin
        mode_nxt    = mode_dec;
        per_cnt_nxt = '0;
        if (active && (mode_dec == mode_r) && (ctrl_nxt == ctrl_r) &&
            (param_nxt == param_r)) begin
            if (per_cnt_r + 1'b1 >= period_cyc) begin
                per_cnt_nxt = '0;
            end else begin
                per_cnt_nxt = per_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r    <= MODE_OFF;
            per_cnt_r <= '0;
        end else begin
            mode_r    <= mode_nxt;
            per_cnt_r <= per_cnt_nxt;
        end
    end

    // Z starts each period, Y follows by the scaled offset
    assign gp_z.start     = active && (per_cnt_r == '0);
    assign gp_y.start     = active && (per_cnt_r == offset_cyc);
    assign gp_z.enable    = active;
    assign gp_y.enable    = active;
    assign gp_z.on_cap    = cap_cyc;
    assign gp_y.on_cap    = cap_cyc;
    assign gp_z.blank_cyc = blank_cyc;
    assign gp_y.blank_cyc = blank_cyc;
    assign gp_z.trip      = current_sense_in_z;
    assign gp_y.trip      = current_sense_in_y;

    gate_pulse_timer u_timer_z (
        .pclk    (pclk),
        .presetn (presetn),
        .gp      (gp_z.timer)
    );

    gate_pulse_timer u_timer_y (
        .pclk    (pclk),
        .presetn (presetn),
        .gp      (gp_y.timer)
    );

    assign gate_drive_out_z = gp_z.gate;
    assign gate_drive_out_y = gp_y.gate;

    // APB slave: one wait state, answer registered
    assign access = psel && penable && pready_r;
    assign sel    = decode_addr(paddr);
    assign mapped = (sel != SEL_NONE);
    assign status = {2'b00, mode_r, gp_z.blanking, gp_y.blanking,
                     gp_z.gate, gp_y.gate};

    // Settings change only at the completing edge, never in the wait state
    always_comb begin
        param_nxt = param_r;
        ctrl_nxt  = ctrl_r;
        if (access && pwrite) begin
            if (sel == SEL_PARAM) begin
                param_nxt = pwdata[7:0];
            end else if (sel == SEL_CTRL) begin
                ctrl_nxt = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_r <= PARAM_RST;
            ctrl_r  <= CTRL_RST;
        end else begin
            param_r <= param_nxt;
            ctrl_r  <= ctrl_nxt;
        end
    end

    // Answer is built in the wait state so data and error stand with ready
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt  = psel && penable && !pready_r;
        if (pready_nxt) begin
            // Status is read only; a write to it is refused, not dropped quietly
            pslverr_nxt = !mapped || (pwrite && (sel == SEL_STATUS));
            if (pwrite) begin
                prdata_nxt = '0;
            end else if (sel == SEL_PARAM) begin
                prdata_nxt = {24'h000000, param_r};
            end else if (sel == SEL_CTRL) begin
                prdata_nxt = {24'h000000, ctrl_r};
            end else if (sel == SEL_STATUS) begin
                prdata_nxt = {24'h000000, status};
            end else begin
                prdata_nxt = '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

endmodule

// >>> gate_pwm_properties.sv
`timescale 1ns/1ps
module gate_pwm_checker
    import swg_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        current_sense_in_y,
    input wire logic        current_sense_in_z,
    input wire logic        gate_drive_out_y,
    input wire logic        gate_drive_out_z
);
    logic [7:0] on_y_r;
    logic [7:0] on_y_nxt;
    logic [7:0] on_z_r;
    logic [7:0] on_z_nxt;

    // Cycles each gate has been high so far
    always_comb begin
        on_y_nxt = gate_drive_out_y ? on_y_r + 8'h01 : 8'h00;
        on_z_nxt = gate_drive_out_z ? on_z_r + 8'h01 : 8'h00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_y_r <= 8'h00;
            on_z_r <= 8'h00;
        end else begin
            on_y_r <= on_y_nxt;
            on_z_r <= on_z_nxt;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wait_s;
        psel && penable && !pready;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence

    apb_wait_a: assert property (setup_s |=> wait_s ##1 done_s)
        else $error("no ready after one wait state");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    on_time_y_a: assert property (gate_drive_out_y |-> on_y_r <= 8'd100)
        else $error("y gate on too long");
    on_time_z_a: assert property (gate_drive_out_z |-> on_z_r <= 8'd100)
        else $error("z gate on too long");
    blank_y_a: assert property ($rose(gate_drive_out_y) |-> gate_drive_out_y[*5])
        else $error("y pulse cut inside blanking");
    trip_end_y_a: assert property (
        gate_drive_out_y && current_sense_in_y && on_y_r >= 8'd17 |-> ##[1:2] !gate_drive_out_y)
        else $error("y pulse not ended by trip");
    reset_quiet_a: assert property (@(posedge pclk) disable iff (1'b0)
        !presetn |-> !gate_drive_out_y && !gate_drive_out_z && !pready)
        else $error("outputs active in reset");
endmodule

bind switcher_gate_pwm_timing gate_pwm_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .current_sense_in_y(current_sense_in_y),
    .current_sense_in_z(current_sense_in_z), .gate_drive_out_y(gate_drive_out_y),
    .gate_drive_out_z(gate_drive_out_z));

// >>> fet_sense_model.sv
`timescale 1ns/1ps
module fet_sense_model (
    input  wire logic       pclk,
    input  wire logic       gate_y,
    input  wire logic       gate_z,
    input  wire logic [7:0] trip_dly,
    output logic            sense_y,
    output logic            sense_z
);
    logic [7:0] cy = 8'h00;
    logic [7:0] cz = 8'h00;

    always @(posedge pclk) begin
        cy <= gate_y ? cy + 8'h01 : 8'h00;
        cz <= gate_z ? cz + 8'h01 : 8'h00;
    end
    // Turn-on spike on every pulse, then a trip after trip_dly; zero never trips
    assign sense_y = gate_y && (cy < 8'd2 || (trip_dly != 8'h00 && cy >= trip_dly));
    assign sense_z = gate_z && (cz < 8'd2 || (trip_dly != 8'h00 && cz >= trip_dly));
endmodule

// >>> switcher_gate_pwm_timing_test.sv
`timescale 1ns/1ps
module switcher_gate_pwm_timing_test;
    import swg_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, er, gz_q, gy_q;
    logic        sense_y, sense_z, gate_y, gate_z;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'd57277;
    logic [7:0]  trip_dly;
    int          n_mismatch = 0, n_tests = 0, cyc = 0, zr0 = 0, zr1 = 0, zw = 0, yoff = 0;
    int          per, b, d, eff;
    int          blk[4] = '{BLANK0_CYC, BLANK1_CYC, BLANK2_CYC, BLANK3_CYC};

    always #5 pclk = ~pclk;

    switcher_gate_pwm_timing #(.LP_PERIOD(13'd400)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .current_sense_in_y(sense_y),
        .current_sense_in_z(sense_z), .gate_drive_out_y(gate_y), .gate_drive_out_z(gate_z));
    fet_sense_model fet (.pclk(pclk), .gate_y(gate_y), .gate_z(gate_z), .trip_dly(trip_dly),
        .sense_y(sense_y), .sense_z(sense_z));

    // Edge timestamps of the gates, in cycles
    always @(posedge pclk) begin
        cyc  <= cyc + 1;
        gz_q <= gate_z;
        gy_q <= gate_y;
        if (gate_z && !gz_q) begin
            zr1 <= cyc;
            zr0 <= zr1;
        end
        if (!gate_z && gz_q) zw <= cyc - zr1;
        if (gate_y && !gy_q) yoff <= cyc - zr1;
    end

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function int cap(input int p, input int pm);
        cap = (p * pm / 1000 < 101) ? p * pm / 1000 : 101;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Long enough for two fresh turn-ons after a change
    task settle(input int p);
        repeat (3 * p + 200) @(posedge pclk);
    endtask

    task end_sim;
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        // About three times the expected run
        #400000;
        n_mismatch++;
        end_sim;
    end

    initial begin
        presetn <= 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        trip_dly = 8'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PARAM_ADDR, 32'h0);
        chk(rd, 32'h08);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h00);
        apb(1'b1, 12'h004, xs());
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        repeat (600) @(posedge pclk);
        chk(zr1, 32'h0);
        for (int m = 1; m <= 3; m++) begin
            per = (m == 1) ? 400 : (m == 2) ? 260 : 195;
            rd = xs();
            apb(1'b1, PARAM_ADDR, {rd[31:8], 8'h04});
            apb(1'b0, PARAM_ADDR, 32'h0);
            chk(rd, 32'h04);
            apb(1'b1, CTRL_ADDR, {24'h0, m[7:0]});
            settle(per);
            chk(zr1 - zr0, per);
            chk(zw, cap(per, (m == 1) ? 25 : (m == 2) ? 304 : 520));
            chk(yoff, 130);
        end
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk(rd & 32'hFFFFFF30, 32'h00000030);
        for (int f = 1; f <= 3; f++) begin
            apb(1'b1, PARAM_ADDR, 32'h04 | f);
            settle(195);
            chk(zr1 - zr0, 195 / (f + 1));
            chk(yoff, 130 / (f + 1));
        end
        for (int i = 0; i < 8; i++) begin
            b = xs() % 4;
            d = 3 + xs() % 40;
            trip_dly <= d[7:0];
            apb(1'b1, PARAM_ADDR, b << 2);
            settle(195);
            eff = (d > blk[b]) ? d : blk[b];
            chk({31'h0, zw >= eff && zw <= eff + 3}, 32'h1);
        end
        rd = xs();
        apb(1'b1, CTRL_ADDR, {24'h0, 1'b1, rd[6:0]});
        repeat (20) @(posedge pclk);
        d = zr1;
        repeat (600) @(posedge pclk);
        chk(zr1, d);
        chk({31'h0, gate_z | gate_y}, 32'h0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h00);
        apb(1'b0, PARAM_ADDR, 32'h0);
        chk(rd, 32'h08);
        end_sim;
    end
endmodule
